// >>> core/pwf_regs.svh
// Constants for the pin-function and pulse-output configuration block
`ifndef PWF_REGS_SVH
`define PWF_REGS_SVH

// Reset values
`define PWF_ASSOC_FUNC_RST 3'h1
`define PWF_SLPRQ_FUNC_RST 3'h1
`define PWF_SLPIND_FUNC_RST 3'h1
`define PWF_L10_FUNC_RST 3'h1
`define PWF_L11_FUNC_RST 3'h0
`define PWF_L12_FUNC_RST 3'h0
`define PWF_PULL_EN_RST 20'h0ffff
`define PWF_PULL_DIR_RST 20'h0ffff
`define PWF_DUTY_RST 10'h000

// Field limits
`define PWF_MASK_MAX_TH 20'h0ffff
`define PWF_MASK_MAX_SMT 20'hfffff
`define PWF_DUTY_MAX 10'h3ff
`define PWF_LEVEL_MAP_W 8

// Line numbers handled here
`define PWF_LINE_ASSOC 5
`define PWF_LINE_SLPRQ 8
`define PWF_LINE_SLPIND 9
`define PWF_LINE_10 10
`define PWF_LINE_11 11
`define PWF_LINE_12 12

// Timing
`define PWF_CLK_PERIOD_NS 5
`define PWF_PWM_PERIOD_NS 64000
`define PWF_PWM_STEPS 1023
`define PWF_PWM_STEP_CYC ((`PWF_PWM_PERIOD_NS / `PWF_CLK_PERIOD_NS) / `PWF_PWM_STEPS)
`define PWF_TICK_MS 10
`define PWF_TICK_CYC ((`PWF_TICK_MS * 1000000) / `PWF_CLK_PERIOD_NS)
`define PWF_BLINK_DEF_MS 250
`define PWF_BLINK_DEF_TICKS (`PWF_BLINK_DEF_MS / `PWF_TICK_MS)
`define PWF_RSSI_UNIT_MS 100
`define PWF_RSSI_UNIT_TICKS (`PWF_RSSI_UNIT_MS / `PWF_TICK_MS)
`define PWF_RSSI_FOREVER 8'hff

`endif

// >>> core/pwf_pkg.sv
// Types shared by the pin-function configuration block
package pwf_pkg;

    typedef enum logic [3:0] {
        SEL_ASSOC_FUNC = 4'h0,
        SEL_SLPRQ_FUNC = 4'h1,
        SEL_SLPIND_FUNC = 4'h2,
        SEL_L10_FUNC = 4'h3,
        SEL_L11_FUNC = 4'h4,
        SEL_L12_FUNC = 4'h5,
        SEL_PULL_EN = 4'h6,
        SEL_PULL_DIR = 4'h7,
        SEL_LEVEL_MAP = 4'h8,
        SEL_DUTY_ZERO = 4'h9,
        SEL_DUTY_ONE = 4'ha
    } pwf_sel_t;

    typedef enum logic [2:0] {
        FN_DISABLED = 3'h0,
        FN_SPECIAL = 3'h1,
        FN_PULSE = 3'h2,
        FN_INPUT = 3'h3,
        FN_OUT_LOW = 3'h4,
        FN_OUT_HIGH = 3'h5
    } pwf_func_t;

    typedef struct packed {
        logic valid;
        logic write;
        pwf_sel_t sel;
        logic [19:0] wdata;
    } pwf_cmd_t;

    typedef struct packed {
        logic [19:0] out;
        logic [19:0] oe;
        logic [19:0] pull_en;
        logic [19:0] pull_up;
    } pwf_pins_t;

endpackage

// >>> core/pwf_pwm.sv
// Fixed-period pulse-width generator with a 10-bit duty value
`timescale 1ns/1ps
`include "pwf_regs.svh"

module pwf_pwm #(
    parameter int STEP_CYC = `PWF_PWM_STEP_CYC,
    parameter int STEPS = `PWF_PWM_STEPS
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Control
    input wire logic i_enable,
    input wire logic [9:0] i_duty,
    // Output
    output logic o_pwm
);

    if (STEP_CYC < 1 || STEPS < 2 || STEPS > 1023) begin : g_chk
        $error("pwf_pwm: step settings out of range");
    end

    logic [11:0] step_cnt_ff;
    logic [9:0] phase_ff;
    logic pwm_ff;

    wire step_end = step_cnt_ff == 12'(STEP_CYC - 1);
    wire phase_end = phase_ff == 10'(STEPS - 1);
    // Phase runs 0..STEPS-1, so full-scale duty holds high all period
    wire nxt_pwm = i_enable && (phase_ff < i_duty);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            step_cnt_ff <= 12'h000;
        end else begin
            step_cnt_ff <= step_end ? 12'h000 : step_cnt_ff + 12'h001;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            phase_ff <= 10'h000;
        end else if (step_end) begin
            phase_ff <= phase_end ? 10'h000 : phase_ff + 10'h001;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pwm_ff <= 1'b0;
        end else begin
            pwm_ff <= nxt_pwm;
        end
    end

    assign o_pwm = pwm_ff;

endmodule

// >>> core/pwf_top.sv
// Pin-function selection, pull control, level map and pulse outputs
`timescale 1ns/1ps
`include "pwf_regs.svh"

module pwf_top #(
    parameter bit THROUGH_HOLE = 1'b0,
    parameter int TICK_CYC = `PWF_TICK_CYC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Command-mode access
    input wire pwf_pkg::pwf_cmd_t i_cmd,
    input wire logic i_apply_changes,
    output logic o_cmd_done,
    output logic o_cmd_error,
    output logic [19:0] o_cmd_rdata,
    // Settings owned elsewhere
    input wire logic [7:0] i_led_blink_time,
    input wire logic [7:0] i_signal_strength_timer,
    input wire logic [19:0] i_ext_pull_ok,
    // Node state and radio events
    input wire logic i_associated,
    input wire logic i_asleep,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_strength_dbm,
    input wire logic i_analog_in_zero_valid,
    input wire logic [9:0] i_analog_in_zero,
    input wire logic i_line_passing_match,
    input wire logic i_spi_miso_data,
    // Pins
    input wire logic [19:0] i_line_in,
    output pwf_pkg::pwf_pins_t o_pins,
    output logic o_sleep_request_in
);

    localparam int MASK_W = THROUGH_HOLE ? 16 : 20;

    if (TICK_CYC < 2 || TICK_CYC > 16777215) begin : g_chk
        $error("pwf_top: TICK_CYC out of range");
    end

    // Function code legality per line
    function automatic logic code_ok(input pwf_pkg::pwf_sel_t sel, input logic [2:0] c);
        logic std;
        std = (c == 3'h0) || (c == 3'h3) || (c == 3'h4) || (c == 3'h5);
        case (sel)
            pwf_pkg::SEL_L10_FUNC: code_ok = std || (c == 3'h1) || (c == 3'h2);
            pwf_pkg::SEL_L11_FUNC: code_ok = std || (c == 3'h2);
            pwf_pkg::SEL_L12_FUNC: code_ok = std || ((c == 3'h1) && THROUGH_HOLE);
            default: code_ok = std || (c == 3'h1);
        endcase
    endfunction

    // Mask bit position serving a given line
    function automatic logic [4:0] pull_bit(input int line);
        case (line)
            0: pull_bit = 5'h04;
            1: pull_bit = 5'h03;
            2: pull_bit = 5'h02;
            3: pull_bit = 5'h01;
            4: pull_bit = 5'h00;
            5: pull_bit = 5'h08;
            6: pull_bit = 5'h05;
            7: pull_bit = 5'h0d;
            8: pull_bit = 5'h06;
            9: pull_bit = 5'h09;
            10: pull_bit = 5'h0b;
            11: pull_bit = 5'h0c;
            12: pull_bit = 5'h0a;
            13: pull_bit = 5'h0e;
            14: pull_bit = 5'h07;
            default: pull_bit = 5'(line);
        endcase
    endfunction

    // Static drive of a plain digital function
    function automatic logic [1:0] std_drive(input logic [2:0] f, input logic lvl);
        std_drive = {(f == 3'h4) || (f == 3'h5), lvl};
    endfunction

    // Pending (written) and active (applied) settings
    logic [2:0] p_func_ff [6];
    logic [2:0] a_func_ff [6];
    logic [19:0] p_pull_en_ff;
    logic [19:0] p_pull_dir_ff;
    logic [19:0] a_pull_en_ff;
    logic [19:0] a_pull_dir_ff;
    logic [9:0] p_duty0_ff;
    logic [9:0] p_duty1_ff;
    logic [9:0] a_duty0_ff;
    logic [9:0] a_duty1_ff;
    logic [5:0] level_ff;
    logic done_ff;
    logic err_ff;
    logic [19:0] rdata_ff;

    // Command decode
    wire is_func = i_cmd.sel <= pwf_pkg::SEL_L12_FUNC;
    wire [2:0] func_idx = i_cmd.sel[2:0];
    wire [19:0] mask_max = THROUGH_HOLE ? `PWF_MASK_MAX_TH : `PWF_MASK_MAX_SMT;
    wire is_mask = (i_cmd.sel == pwf_pkg::SEL_PULL_EN) || (i_cmd.sel == pwf_pkg::SEL_PULL_DIR);
    wire is_duty = (i_cmd.sel == pwf_pkg::SEL_DUTY_ZERO) || (i_cmd.sel == pwf_pkg::SEL_DUTY_ONE);
    wire sel_known = i_cmd.sel <= pwf_pkg::SEL_DUTY_ONE;
    wire bad_code = is_func && ((i_cmd.wdata[19:3] != 17'h00000) ||
        !code_ok(i_cmd.sel, i_cmd.wdata[2:0]));
    wire bad_mask = is_mask && (i_cmd.wdata > mask_max);
    wire bad_duty = is_duty && (i_cmd.wdata[19:10] != 10'h000);
    wire bad_lvl = (i_cmd.sel == pwf_pkg::SEL_LEVEL_MAP) &&
        (i_cmd.wdata[19:`PWF_LEVEL_MAP_W] != 12'h000);
    wire cmd_err = i_cmd.valid && (!sel_known || (i_cmd.write &&
        (bad_code || bad_mask || bad_duty || bad_lvl)));
    wire wr_ok = i_cmd.valid && i_cmd.write && !cmd_err;
    wire rd_ok = i_cmd.valid && !i_cmd.write && sel_known;

    logic [19:0] nxt_rdata;
    always_comb begin
        case (i_cmd.sel)
            pwf_pkg::SEL_PULL_EN: nxt_rdata = p_pull_en_ff;
            pwf_pkg::SEL_PULL_DIR: nxt_rdata = p_pull_dir_ff;
            pwf_pkg::SEL_DUTY_ZERO: nxt_rdata = {10'h000, p_duty0_ff};
            pwf_pkg::SEL_DUTY_ONE: nxt_rdata = {10'h000, p_duty1_ff};
            pwf_pkg::SEL_LEVEL_MAP: nxt_rdata = 20'h00000;
            default: nxt_rdata = is_func ? {17'h00000, p_func_ff[func_idx]} : 20'h00000;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            done_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= 20'h00000;
        end else begin
            done_ff <= i_cmd.valid && !cmd_err;
            err_ff <= cmd_err;
            rdata_ff <= rd_ok ? nxt_rdata : rdata_ff;
        end
    end

    // Pending settings; apply copies them into the active set
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            p_func_ff[0] <= `PWF_ASSOC_FUNC_RST;
            p_func_ff[1] <= `PWF_SLPRQ_FUNC_RST;
            p_func_ff[2] <= `PWF_SLPIND_FUNC_RST;
            p_func_ff[3] <= `PWF_L10_FUNC_RST;
            p_func_ff[4] <= `PWF_L11_FUNC_RST;
            p_func_ff[5] <= `PWF_L12_FUNC_RST;
            p_pull_en_ff <= `PWF_PULL_EN_RST;
            p_pull_dir_ff <= `PWF_PULL_DIR_RST;
            p_duty0_ff <= `PWF_DUTY_RST;
            p_duty1_ff <= `PWF_DUTY_RST;
        end else if (wr_ok) begin
            if (is_func) begin
                p_func_ff[func_idx] <= i_cmd.wdata[2:0];
            end
            if (i_cmd.sel == pwf_pkg::SEL_PULL_EN) begin
                p_pull_en_ff <= i_cmd.wdata;
            end
            if (i_cmd.sel == pwf_pkg::SEL_PULL_DIR) begin
                p_pull_dir_ff <= i_cmd.wdata;
            end
            if (i_cmd.sel == pwf_pkg::SEL_DUTY_ZERO) begin
                p_duty0_ff <= i_cmd.wdata[9:0];
            end
            if (i_cmd.sel == pwf_pkg::SEL_DUTY_ONE) begin
                p_duty1_ff <= i_cmd.wdata[9:0];
            end
        end
    end

    // Passing a sample only counts while line 10 is really in pulse mode
    wire pass0 = i_analog_in_zero_valid && i_line_passing_match &&
        (a_func_ff[3] == 3'h2);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            a_func_ff[0] <= `PWF_ASSOC_FUNC_RST;
            a_func_ff[1] <= `PWF_SLPRQ_FUNC_RST;
            a_func_ff[2] <= `PWF_SLPIND_FUNC_RST;
            a_func_ff[3] <= `PWF_L10_FUNC_RST;
            a_func_ff[4] <= `PWF_L11_FUNC_RST;
            a_func_ff[5] <= `PWF_L12_FUNC_RST;
            a_pull_en_ff <= `PWF_PULL_EN_RST;
            a_pull_dir_ff <= `PWF_PULL_DIR_RST;
            a_duty1_ff <= `PWF_DUTY_RST;
        end else if (i_apply_changes) begin
            a_func_ff <= p_func_ff;
            a_pull_en_ff <= p_pull_en_ff;
            a_pull_dir_ff <= p_pull_dir_ff;
            a_duty1_ff <= p_duty1_ff;
        end
    end

    // Apply wins over a passed sample arriving in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            a_duty0_ff <= `PWF_DUTY_RST;
        end else if (i_apply_changes) begin
            a_duty0_ff <= p_duty0_ff;
        end else if (pass0) begin
            a_duty0_ff <= i_analog_in_zero;
        end
    end

    // Output levels: set by apply from codes 4/5, then the line 5 level only by level-map writes
    wire lvl_wr = wr_ok && (i_cmd.sel == pwf_pkg::SEL_LEVEL_MAP);
    logic [5:0] nxt_level;
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            nxt_level[i] = i_apply_changes ? (p_func_ff[i] == 3'h5) : level_ff[i];
        end
        if (lvl_wr) begin
            nxt_level[0] = i_cmd.wdata[`PWF_LINE_ASSOC];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            level_ff <= 6'h00;
        end else begin
            level_ff <= nxt_level;
        end
    end

    // 10 ms time base
    logic [23:0] tick_cnt_ff;
    wire tick = tick_cnt_ff == 24'(TICK_CYC - 1);
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tick_cnt_ff <= 24'h000000;
        end else begin
            tick_cnt_ff <= tick ? 24'h000000 : tick_cnt_ff + 24'h000001;
        end
    end

    // Associate blink, equal on and off phases
    logic [7:0] blink_cnt_ff;
    logic blink_ff;
    wire [7:0] half_ticks = (i_led_blink_time == 8'h00) ?
        8'(`PWF_BLINK_DEF_TICKS) : i_led_blink_time;
    wire blink_end = tick && (blink_cnt_ff >= half_ticks - 8'h01);
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_associated) begin
            blink_cnt_ff <= 8'h00;
            blink_ff <= 1'b0;
        end else if (blink_end) begin
            blink_cnt_ff <= 8'h00;
            blink_ff <= !blink_ff;
        end else if (tick) begin
            blink_cnt_ff <= blink_cnt_ff + 8'h01;
        end
    end

    // Signal-strength pulse: duty per packet, window in 100 ms units
    logic [11:0] rssi_left_ff;
    logic [9:0] rssi_duty_ff;
    wire rssi_forever = i_signal_strength_timer == `PWF_RSSI_FOREVER;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rssi_left_ff <= 12'h000;
            rssi_duty_ff <= 10'h000;
        end else if (i_rx_valid) begin
            // Stronger signal (fewer dBm below zero) gives more high time
            rssi_duty_ff <= `PWF_DUTY_MAX - {i_rx_strength_dbm, 2'b00};
            rssi_left_ff <= 12'(i_signal_strength_timer * `PWF_RSSI_UNIT_TICKS);
        end else if (tick && rssi_left_ff != 12'h000) begin
            rssi_left_ff <= rssi_left_ff - 12'h001;
        end
    end
    wire rssi_on = rssi_forever || (rssi_left_ff != 12'h000);

    // Pulse generators
    wire l10_rssi = a_func_ff[3] == 3'h1;
    wire l10_pwm = a_func_ff[3] == 3'h2;
    wire l11_pwm = a_func_ff[4] == 3'h2;
    wire pwm_rssi;
    wire pwm_zero;
    wire pwm_one;

    pwf_pwm u_pwm_rssi (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_enable(l10_rssi && rssi_on),
        .i_duty(rssi_duty_ff),
        .o_pwm(pwm_rssi)
    );

    pwf_pwm u_pwm_zero (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_enable(l10_pwm),
        .i_duty(a_duty0_ff),
        .o_pwm(pwm_zero)
    );

    pwf_pwm u_pwm_one (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_enable(l11_pwm),
        .i_duty(a_duty1_ff),
        .o_pwm(pwm_one)
    );

    // Sleep-request pin enters through a two-stage synchroniser
    logic slprq_meta_ff;
    logic slprq_sync_ff;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            slprq_meta_ff <= 1'b0;
            slprq_sync_ff <= 1'b0;
        end else begin
            slprq_meta_ff <= i_line_in[`PWF_LINE_SLPRQ];
            slprq_sync_ff <= slprq_meta_ff;
        end
    end
    wire slprq_fn = a_func_ff[1] == 3'h1;
    wire nxt_slprq = slprq_fn && slprq_sync_ff;

    // Per-line drive of the six handled lines, {oe, level}
    logic [1:0] drv [6];
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            drv[i] = std_drive(a_func_ff[i], level_ff[i]);
        end
        if (a_func_ff[0] == 3'h1) begin
            drv[0] = {1'b1, i_associated && blink_ff};
        end
        if (slprq_fn) begin
            drv[1] = 2'b00;
        end
        if (a_func_ff[2] == 3'h1) begin
            drv[2] = {1'b1, !i_asleep};
        end
        if (l10_rssi) begin
            drv[3] = {1'b1, pwm_rssi};
        end
        if (l10_pwm) begin
            drv[3] = {1'b1, pwm_zero};
        end
        if (l11_pwm) begin
            drv[4] = {1'b1, pwm_one};
        end
        if (a_func_ff[5] == 3'h1) begin
            drv[5] = {1'b1, i_spi_miso_data};
        end
    end

    // Pull control across all twenty lines
    localparam int LINES [6] = '{`PWF_LINE_ASSOC, `PWF_LINE_SLPRQ, `PWF_LINE_SLPIND,
        `PWF_LINE_10, `PWF_LINE_11, `PWF_LINE_12};
    logic [19:0] pull_ok;
    pwf_pkg::pwf_pins_t nxt_pins;
    always_comb begin
        pull_ok = i_ext_pull_ok;
        nxt_pins = '0;
        for (int i = 0; i < 6; i++) begin
            pull_ok[LINES[i]] = (a_func_ff[i] == 3'h0) || (a_func_ff[i] == 3'h3);
            nxt_pins.oe[LINES[i]] = drv[i][1];
            nxt_pins.out[LINES[i]] = drv[i][1] && drv[i][0];
        end
        for (int l = 0; l < 20; l++) begin
            // Bits above the variant's mask width never reach a pin
            nxt_pins.pull_en[l] = (int'(pull_bit(l)) < MASK_W) && pull_ok[l] &&
                a_pull_en_ff[pull_bit(l)];
            nxt_pins.pull_up[l] = nxt_pins.pull_en[l] && a_pull_dir_ff[pull_bit(l)];
        end
    end

    pwf_pkg::pwf_pins_t pins_ff;
    logic slprq_out_ff;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pins_ff <= '0;
            slprq_out_ff <= 1'b0;
        end else begin
            pins_ff <= nxt_pins;
            slprq_out_ff <= nxt_slprq;
        end
    end

    assign o_pins = pins_ff;
    assign o_sleep_request_in = slprq_out_ff;
    assign o_cmd_done = done_ff;
    assign o_cmd_error = err_ff;
    assign o_cmd_rdata = rdata_ff;

endmodule

// >>> dv/pwf_top_properties.sv
// Port-level checks for the pin-function block
`timescale 1ns/1ps
module pwf_top_properties (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Command port and pins
    input wire pwf_pkg::pwf_cmd_t i_cmd,
    input wire logic o_cmd_done,
    input wire logic o_cmd_error,
    input wire pwf_pkg::pwf_pins_t o_pins,
    input wire logic o_sleep_request_in
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_cmd_answered: assert property (i_cmd.valid |=> o_cmd_done != o_cmd_error)
        else $error("command not answered exactly once");
    a_bad_sel: assert property (i_cmd.valid && i_cmd.sel > 4'ha |=> o_cmd_error)
        else $error("unknown select accepted");
    a_duty_range: assert property (i_cmd.valid && i_cmd.write
        && i_cmd.sel == pwf_pkg::SEL_DUTY_ZERO && i_cmd.wdata[19:10] != 10'h000 |=> o_cmd_error)
        else $error("duty above range accepted");
    a_map_range: assert property (i_cmd.valid && i_cmd.write
        && i_cmd.sel == pwf_pkg::SEL_LEVEL_MAP && i_cmd.wdata[19:8] != 12'h000 |=> o_cmd_error)
        else $error("level map above eight bits accepted");
    a_code_refused: assert property (i_cmd.valid && i_cmd.write &&
        (i_cmd.sel == pwf_pkg::SEL_ASSOC_FUNC && i_cmd.wdata == 20'h00002 ||
        i_cmd.sel == pwf_pkg::SEL_L11_FUNC && i_cmd.wdata == 20'h00001) |=> o_cmd_error)
        else $error("unsupported function code accepted");
    a_line10_codes: assert property (i_cmd.valid && i_cmd.write
        && i_cmd.sel == pwf_pkg::SEL_L10_FUNC && i_cmd.wdata <= 20'h00005 |=> o_cmd_done)
        else $error("line 10 code refused");
    a_pull_undriven: assert property ((o_pins.pull_en & o_pins.oe) == 20'h00000)
        else $error("pull on a driven line");
    a_sleep_float: assert property (o_sleep_request_in |-> !o_pins.oe[8] && !o_pins.pull_en[8])
        else $error("sleep request line driven or pulled");
endmodule

bind pwf_top pwf_top_properties pwf_top_properties_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_cmd(i_cmd), .o_cmd_done(o_cmd_done), .o_cmd_error(o_cmd_error), .o_pins(o_pins),
    .o_sleep_request_in(o_sleep_request_in));

// >>> dv/pwf_host.sv
// Host model issuing configuration commands and apply strobes
`timescale 1ns/1ps
module pwf_host (
    // Clock
    input wire logic i_clk_sys,
    // Commands
    output pwf_pkg::pwf_cmd_t o_cmd,
    output logic o_apply
);
    initial begin
        o_cmd = '0;
        o_apply = 1'b0;
    end
    // One command per call; answer is settled on return
    task automatic cmd(input logic w, input logic [3:0] s, input logic [19:0] d);
        @(posedge i_clk_sys);
        o_cmd <= '{1'b1, w, pwf_pkg::pwf_sel_t'(s), d};
        @(posedge i_clk_sys);
        o_cmd <= '0;
        #1;
    endtask
    // Written settings other than the level map stay pending until this strobe
    task automatic apply();
        @(posedge i_clk_sys);
        o_apply <= 1'b1;
        @(posedge i_clk_sys);
        o_apply <= 1'b0;
        #1;
    endtask
endmodule

// >>> dv/pwf_top_tb.sv
// Self-checking bench for the pin-function block
`timescale 1ns/1ps
module pwf_top_tb;
    logic clk, rst, assoc, asleep, rxv, av, match, apply, done, err, sreq;
    logic [9:0] ain;
    logic [7:0] dbm, rpt;
    logic [19:0] rdata, line_in;
    logic [19:0] rst_v [10] = '{20'h1, 20'h1, 20'h1, 20'h1, 20'h0, 20'h0,
        20'h0ffff, 20'h0ffff, 20'h0, 20'h0};
    pwf_pkg::pwf_cmd_t cmd;
    pwf_pkg::pwf_pins_t pins;
    int errors, num_checks, hi;

    pwf_top #(.TICK_CYC(20)) pwf_top_i (.i_clk_sys(clk), .i_rst(rst), .i_cmd(cmd),
        .i_apply_changes(apply), .o_cmd_done(done), .o_cmd_error(err), .o_cmd_rdata(rdata),
        .i_led_blink_time(8'h00), .i_signal_strength_timer(rpt), .i_ext_pull_ok(20'h0),
        .i_associated(assoc), .i_asleep(asleep), .i_rx_valid(rxv), .i_rx_strength_dbm(dbm),
        .i_analog_in_zero_valid(av), .i_analog_in_zero(ain), .i_line_passing_match(match),
        .i_spi_miso_data(1'b0), .i_line_in(line_in), .o_pins(pins), .o_sleep_request_in(sreq));
    pwf_host pwf_host_i (.i_clk_sys(clk), .o_cmd(cmd), .o_apply(apply));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] s, input logic [19:0] d, input logic bad);
        pwf_host_i.cmd(1'b1, s, d);
        chk({18'h0, err, done}, {18'h0, bad, !bad});
    endtask
    task automatic rd(input logic [3:0] s, input logic [19:0] e);
        pwf_host_i.cmd(1'b0, s, 20'h0);
        chk(rdata, e);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Window of a whole period, so the phase does not matter
    task automatic count(input int n, input int line);
        hi = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            hi += int'(pins.out[line]);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        test_done();
    end

    initial begin
        errors = 0;
        num_checks = 0;
        {rst, assoc, asleep, rxv, av, match} = 6'h21;
        ain = 10'h0;
        {dbm, rpt} = 16'h0001;
        line_in = 20'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(4'(i), rst_v[i]);
        end
        $display("test reset values done");
        @(posedge clk);
        line_in <= 20'h00100;
        rxv <= 1'b1;
        @(posedge clk);
        rxv <= 1'b0;
        settle(4);
        chk(20'(sreq), 20'h1);
        chk({18'h0, pins.oe[8], pins.pull_en[8]}, 20'h0);
        chk({18'h0, pins.oe[9], pins.out[9]}, 20'h3);
        chk(20'(pins.out[10]), 20'h1);
        @(posedge clk);
        asleep <= 1'b1;
        assoc <= 1'b1;
        settle(3);
        chk(20'(pins.out[9]), 20'h0);
        settle(600);
        count(1000, 5);
        chk(20'(hi), 20'h001f4);
        // One 100 ms unit is long gone, so the strength output is off
        chk(20'(pins.out[10]), 20'h0);
        @(posedge clk);
        {rxv, rpt, dbm} <= {1'b1, 8'hff, 8'h40};
        @(posedge clk);
        rxv <= 1'b0;
        settle(3);
        count(12276, 10);
        chk(20'(hi), 20'h023f4);
        $display("test indicators done");
        for (int s = 0; s < 6; s++) begin
            for (int c = 0; c < 8; c++) begin
                wr(4'(s), 20'(c), c > 5 || (c == 2 && s != 3 && s != 4) ||
                    (c == 1 && s > 3));
            end
        end
        wr(4'hb, 20'h0, 1'b1);
        rd(4'h0, 20'h5);
        pwf_host_i.apply();
        settle(2);
        chk(pins.oe, 20'h01f20);
        chk(pins.out, 20'h01f20);
        chk(pins.pull_en, 20'h0);
        wr(4'h8, 20'h0, 1'b0);
        wr(4'h8, 20'h00100, 1'b1);
        settle(2);
        chk(20'(pins.out[5]), 20'h0);
        $display("test codes and levels done");
        wr(4'h6, 20'hfffff, 1'b0);
        rd(4'h6, 20'hfffff);
        wr(4'h4, 20'h3, 1'b0);
        wr(4'h6, 20'h01000, 1'b0);
        wr(4'h7, 20'h01000, 1'b0);
        pwf_host_i.apply();
        settle(2);
        chk(pins.pull_en, 20'h00800);
        chk(pins.pull_up, 20'h00800);
        $display("test pulls done");
        wr(4'h9, 20'h00400, 1'b1);
        wr(4'h3, 20'h2, 1'b0);
        wr(4'h9, 20'h001ff, 1'b0);
        pwf_host_i.apply();
        settle(3);
        count(12276, 10);
        chk(20'(hi), 20'h017f4);
        @(posedge clk);
        {match, av} <= 2'h3;
        ain <= 10'h3ff;
        @(posedge clk);
        av <= 1'b0;
        settle(3);
        count(12276, 10);
        chk(20'(hi), 20'h02ff4);
        $display("test pulse output done");
        test_done();
    end
endmodule
